// ===== bench/fdis_drive_model.sv
// Purpose: behavioural floppy drive cable feeding the status block
// Assumes: the bench picks the levels, the drive moves them after an edge
// Notes:   levels stay put between changes, as a real drive cable does

`timescale 1ns/100ps

module fdis_drive_model (
  input wire logic CLK_I,        // block clock
  input wire logic [5:0] want_i, // {change_n, fault, wprot, ready, track0, two_sided}
  output logic [5:0] pins_o      // levels on the cable
);
  // ----------------------------------------------------------------
  // pin update
  // ----------------------------------------------------------------
  // change_n idles high: no media change seen before the first command
  logic [5:0] lvl_q = 6'h20;  // cable levels, one driver only
  // move only after an edge, so the first sync flop never races the pin
  always @(posedge CLK_I) begin
    lvl_q <= want_i;
  end
  assign pins_o = lvl_q;
endmodule : fdis_drive_model

// ===== bench/fdis_top_tb.sv
// Purpose: self-checking bench of the disk input status block
// Assumes: zero wait AHB-Lite slave, drive pins via the cable model
// Notes:   fixed seed, so every run draws the same settings

`timescale 1ns/100ps

module fdis_top_tb;
  logic clk = 1'h0; // 200 MHz
  logic rst_n = 1'h0; // held low for six cycles
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] hsize = 3'h0;
  logic [5:0] want = 6'h20; // change_n high, other pins low
  logic [5:0] pins;
  logic [31:0] hrdata;
  logic hreadyout, hresp, pre_en, dma;
  logic [7:0] drv, drv_s; // drive mask and its sample
  logic [1:0] rate;
  logic [31:0] rd;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  fdis_top uut (
    .CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HREADY_I(hreadyout),
    .HWDATA_I(hwdata), .MEDIA_CHANGED_N_I(pins[5]), .DRIVE_FAULT_I(pins[4]),
    .WRITE_PROT_I(pins[3]), .DRIVE_READY_I(pins[2]), .TRACK_ZERO_I(pins[1]),
    .TWO_SIDED_I(pins[0]), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout),
    .HRESP_O(hresp), .DI_DRIVE_O(drv), .PRECOMP_EN_O(pre_en),
    .RATE_SEL_O(rate), .DMA_ALLOW_O(dma));
  fdis_drive_model drive (.CLK_I(clk), .want_i(want), .pins_o(pins));

  // ----------------------------------------------------------------
  // verdict, timeout and compares
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // the whole run needs a few thousand cycles; a hang stops the run at cycle 20000
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected word at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected pins at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_pin

  // ----------------------------------------------------------------
  // bus master and expectations
  // ----------------------------------------------------------------
  // values read right after an edge are those the edge sampled
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    @(posedge clk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    rdv = hrdata;
    drv_s = drv;
    hsel <= 1'h0;
  endtask : ahb

  // write, then a read whose address phase overlaps the write data phase
  task automatic ahb_wr_rd(input logic [31:0] wa, input logic [31:0] wd,
                           input logic [31:0] ra, output logic [31:0] rdv);
    @(posedge clk);
    hsel <= 1'h1;
    haddr <= wa;
    htrans <= 2'h2;
    hwrite <= 1'h1;
    hsize <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    haddr <= ra;
    hwrite <= 1'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    htrans <= 2'h0;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    rdv = hrdata;
    drv_s = drv;
    hsel <= 1'h0;
  endtask : ahb_wr_rd

  function automatic logic [31:0] adr(input logic [3:0] i);
    return {26'h0, i, 2'h0};
  endfunction : adr

  function automatic logic [7:0] exp_di(input logic [1:0] m, input logic cn,
                                        input logic [2:0] c, input logic d);
    case (m)
      fdis_pkg::MODE_CODE_SECOND: begin
        return {~cn, 4'hF, c[1:0],
                ~(c[1:0] == fdis_pkg::RATE_500K || c[1:0] == fdis_pkg::RATE_1M)};
      end
      fdis_pkg::MODE_CODE_THIRD: return {cn, 3'h0, d, c};
      default: return {~cn, 7'h00}; // low bits undriven, read as zero
    endcase
  endfunction : exp_di

  // program all settings, scribble on the read-only word, then read back
  task automatic setup(input logic [1:0] m, input logic [2:0] c, input logic [3:0] d,
                       input logic [5:0] p);
    logic [7:0] mask;
    mask = (m == fdis_pkg::MODE_CODE_SECOND || m == fdis_pkg::MODE_CODE_THIRD) ?
           8'hFF : 8'h80;
    ahb(1'h1, adr(fdis_pkg::IDX_MODE), {30'h0, m}, rd);
    want <= p;
    ahb(1'h1, adr(fdis_pkg::IDX_CFG_CTRL), {29'h0, c}, rd);
    ahb(1'h1, adr(fdis_pkg::IDX_DIG_OUT), {28'h0, d}, rd);
    ahb(1'h1, adr(fdis_pkg::IDX_DISK_INPUT), $urandom, rd);
    ahb(1'h0, adr(fdis_pkg::IDX_DISK_INPUT), 32'h0, rd);
    chk_word(rd, {24'h0, exp_di(m, p[5], c, d[3])});
    chk_pin(drv_s, mask);
    ahb(1'h0, adr(fdis_pkg::IDX_RESULT3), 32'h0, rd);
    chk_word(rd, {24'h0, p[4:0], d[2:0]});
    chk_pin({3'h0, pre_en, dma, 1'h0, rate}, {3'h0, ~c[2], d[3], 1'h0, c[1:0]});
  endtask : setup

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rd = $urandom(20300);
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    // defaults straight after reset
    chk_pin({3'h0, pre_en, dma, 1'h0, rate}, 8'h12);
    ahb(1'h0, adr(fdis_pkg::IDX_DISK_INPUT), 32'h0, rd);
    chk_word(rd, 32'h0000_0000);
    ahb(1'h1, adr(fdis_pkg::IDX_MODE), {30'h0, fdis_pkg::MODE_CODE_THIRD}, rd);
    ahb(1'h0, adr(fdis_pkg::IDX_DISK_INPUT), 32'h0, rd);
    chk_word(rd, 32'h0000_0082);
    // every mode code, every rate code, both change levels
    for (int i = 0; i < 64; i++) begin
      setup(i[1:0], i[4:2], {i[5], i[2:0]}, {i[0], i[5:1]});
    end
    // unmapped place reads zero with an OKAY answer
    ahb(1'h0, 32'h0000_0040, 32'h0, rd);
    chk_word(rd, 32'h0);
    chk_pin({7'h0, hresp}, 8'h00);
    // the last loop pass left mode 3 (basic), rates 3, precomp off, dma on, change_n high;
    // a third-mode write forwarded into the very next read must show the third layout
    ahb_wr_rd(adr(fdis_pkg::IDX_MODE), {30'h0, fdis_pkg::MODE_CODE_THIRD},
              adr(fdis_pkg::IDX_DISK_INPUT), rd);
    chk_word(rd, {24'h0, exp_di(fdis_pkg::MODE_CODE_THIRD, 1'h1, 3'h7, 1'h1)});
    chk_pin(drv_s, 8'hFF);
    for (int i = 0; i < 60; i++) begin
      setup(2'($urandom), 3'($urandom), 4'($urandom), 6'($urandom));
    end
    final_report();
  end
endmodule : fdis_top_tb

// ===== rtl/fdis_pkg.sv
// Purpose: constants for the floppy digital input status block
// Assumes: AHB-Lite word registers, index times four is the byte address
// Notes:   every offset, code, single-bit field position and register store reset value lives here

package fdis_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_DISK_INPUT = 4'h7;   // disk_input_status, read only
  localparam logic [3:0] IDX_CFG_CTRL = 4'h8;     // config_control
  localparam logic [3:0] IDX_MODE = 4'h9;         // compatibility mode select
  localparam logic [3:0] IDX_DIG_OUT = 4'hA;      // digital output image
  localparam logic [3:0] IDX_RESULT3 = 4'hB;      // result_status_three, read only
  localparam int ADDR_LSB = 2;                    // word aligned
  localparam int ADDR_MSB = 5;                    // top of index field

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CC_PRECOMP_OFF = 2;      // config_control precomp_off
  localparam int CC_RATE_HI = 1;          // config_control rate_select_hi
  localparam int CC_RATE_LO = 0;          // config_control rate_select_lo
  localparam int DO_DMA_ALLOW = 3;        // digital output dma_allow
  localparam int DO_HEAD = 2;             // digital output head_address
  localparam int DO_UNIT_HI = 1;          // digital output unit_select_hi
  localparam int DO_UNIT_LO = 0;          // digital output unit_select_lo
  localparam int DI_CHANGE = 7;           // media_changed_flag position
  localparam int DI_DMA = 3;              // third mode dma mirror
  localparam int DI_PRECOMP = 2;          // third mode precomp mirror
  localparam int DI_DENSE = 0;            // second mode dense_media_n
  localparam int R3_FAULT = 7;            // drive_fault
  localparam int R3_WPROT = 6;            // write protect
  localparam int R3_READY = 5;            // drive_ready
  localparam int R3_TRACK0 = 4;           // track_zero
  localparam int R3_TWO_SIDED = 3;        // two_sided
  localparam int R3_HEAD = 2;             // head_address
  localparam int R3_UNIT_HI = 1;          // unit_select_hi
  localparam int R3_UNIT_LO = 0;          // unit_select_lo

  // ----------------------------------------------------------------
  // constant fields and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DI_SECOND_ONES = 8'h78;  // bits 6..3 read one
  localparam logic [2:0] CC_RESET = 3'h2;         // rates hi=1 lo=0, precomp on
  localparam logic [1:0] MODE_RESET = 2'h0;       // basic layout after reset
  localparam logic [4:0] DO_RESET = 5'h00;        // dma off, unit 0, head 0
  localparam int SYNC_WIDTH = 6;                  // drive pins synchronised

  // ----------------------------------------------------------------
  // mode codes and data-rate codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_CODE_SECOND = 2'h1; // second layout
  localparam logic [1:0] MODE_CODE_THIRD = 2'h2;  // third layout
  localparam logic [1:0] RATE_500K = 2'h0;        // 500 KB/S code
  localparam logic [1:0] RATE_1M = 2'h3;          // 1 MB/S code

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FDIS_BASIC,
    FDIS_SECOND,
    FDIS_THIRD
  } fdis_mode_t;

endpackage : fdis_pkg

// ===== rtl/fdis_sync.sv
// Purpose: two flip-flop synchroniser for a bank of drive pins
// Assumes: inputs are asynchronous levels from the drive cable
// Notes:   first stage is read only by the second stage

`timescale 1ns/100ps

module fdis_sync #(
  parameter int WIDTH = 6,                 // number of pins
  parameter logic [5:0] RESET_VAL = 6'h00  // value held in reset
) (
  input wire logic CLK_I,                  // block clock
  input wire logic RST_N_I,                // synchronous reset, active low
  input wire logic [WIDTH-1:0] async_i,    // raw pin levels
  output logic [WIDTH-1:0] sync_o          // synchronised levels
);

  // ----------------------------------------------------------------
  // one two-stage chain per pin
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_pin
      logic meta_q;  // first stage, metastable
      logic sync_q;  // second stage, safe to use
      // both stages reset to the idle level of the pin
      always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
          meta_q <= RESET_VAL[gi];
          sync_q <= RESET_VAL[gi];
        end else begin
          meta_q <= async_i[gi];
          sync_q <= meta_q;
        end
      end
      assign sync_o[gi] = sync_q;
    end
  endgenerate

endmodule : fdis_sync

// ===== rtl/fdis_top.sv
// Purpose: digital input status and third result byte, AHB-Lite slave
// Assumes: single word transfers, zero wait states, OKAY only
// Notes:   read data are built from next-state values, so a read right
//          after a write already sees the written setting
//
// Function
// - disk input word is 8-bit, read only
// - basic mode: bit 7 is inverted change
// - basic mode: bits 6..0 left undriven
// - second mode: bit 7 is inverted change
// - second mode: bits 6..3 read one
// - second mode: bits 2..1 carry rate select
// - second mode: bit 0 low for dense rates
// - third mode: bit 7 is raw change
// - third mode: bits 6..4 read zero
// - third mode: bit 3 mirrors dma allow
// - third mode: precomp bit 2, rate 1..0
// - third result byte has fixed field layout
// - precomp_off disables write precompensation

`timescale 1ns/100ps

module fdis_top (
  input wire logic CLK_I,              // 200 MHz block clock
  input wire logic RST_N_I,            // synchronous reset, active low
  input wire logic HSEL_I,             // slave select
  input wire logic [31:0] HADDR_I,     // byte address
  input wire logic [1:0] HTRANS_I,     // transfer type
  input wire logic HWRITE_I,           // write when high
  input wire logic [2:0] HSIZE_I,      // transfer size, word expected
  input wire logic HREADY_I,           // bus ready
  input wire logic [31:0] HWDATA_I,    // write data
  input wire logic MEDIA_CHANGED_N_I,  // drive change pin, active low
  input wire logic DRIVE_FAULT_I,      // drive fault pin
  input wire logic WRITE_PROT_I,       // write protect pin
  input wire logic DRIVE_READY_I,      // drive ready pin
  input wire logic TRACK_ZERO_I,       // track zero pin
  input wire logic TWO_SIDED_I,        // two sided media pin
  output logic [31:0] HRDATA_O,        // read data
  output logic HREADYOUT_O,            // slave ready
  output logic HRESP_O,                // always OKAY
  output logic [7:0] DI_DRIVE_O,       // per-bit drive enable of last read
  output logic PRECOMP_EN_O,           // write precompensation on
  output logic [1:0] RATE_SEL_O,       // data rate select to data path
  output logic DMA_ALLOW_O             // dma requests allowed
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pins_raw;   // raw drive levels
  logic [5:0] pins_sync;  // synchronised drive levels
  logic chg_n_s;          // media_changed_n, synchronised
  logic fault_s;          // drive_fault, synchronised
  logic wprot_s;          // write protect, synchronised
  logic ready_s;          // drive_ready, synchronised
  logic track0_s;         // track_zero, synchronised
  logic two_sided_s;      // two_sided, synchronised

  assign pins_raw = {TWO_SIDED_I, TRACK_ZERO_I, DRIVE_READY_I,
                     WRITE_PROT_I, DRIVE_FAULT_I, MEDIA_CHANGED_N_I};

  // change pin idles high so the raw flag reads 1 right after reset
  fdis_sync #(
    .WIDTH(fdis_pkg::SYNC_WIDTH),
    .RESET_VAL(6'h01)
  ) u_sync (
    .CLK_I(CLK_I),
    .RST_N_I(RST_N_I),
    .async_i(pins_raw),
    .sync_o(pins_sync)
  );

  assign chg_n_s = pins_sync[0];
  assign fault_s = pins_sync[1];
  assign wprot_s = pins_sync[2];
  assign ready_s = pins_sync[3];
  assign track0_s = pins_sync[4];
  assign two_sided_s = pins_sync[5];

  // ----------------------------------------------------------------
  // AHB-Lite address phase decode
  // ----------------------------------------------------------------
  logic addr_ok;      // upper address bits zero
  logic xfer;         // transfer taken this edge
  logic ahb_rd;       // read taken this edge
  logic ahb_wr;       // write taken this edge
  logic [3:0] idx;    // register index of address phase
  logic wr_pend_q;    // write data phase pending
  logic [3:0] wr_idx_q;  // index of pending write

  assign addr_ok = (HADDR_I[31:fdis_pkg::ADDR_MSB+1] == 26'h0000000);
  assign idx = HADDR_I[fdis_pkg::ADDR_MSB:fdis_pkg::ADDR_LSB];
  // NONSEQ or SEQ both count; the master only issues NONSEQ
  assign xfer = HSEL_I && HREADY_I && HTRANS_I[1];
  assign ahb_rd = xfer && !HWRITE_I;
  assign ahb_wr = xfer && HWRITE_I && addr_ok;

  // latch the write target until its data phase
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 4'h0;
    end else if (HREADY_I) begin
      wr_pend_q <= ahb_wr;
      wr_idx_q <= idx;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [2:0] cc_q;   // precomp_off, rate_select_hi, rate_select_lo
  logic [2:0] cc_d;   // next config_control
  logic [1:0] mode_q; // compatibility mode code
  logic [1:0] mode_d; // next mode code
  logic [4:0] do_q;   // dma_allow, head_address, unit selects
  logic [4:0] do_d;   // next digital output image
  logic wr_data;      // write data phase this cycle

  assign wr_data = wr_pend_q;

  // next values; the disk input index has no storage, writes fall away
  always_comb begin
    cc_d = cc_q;
    mode_d = mode_q;
    do_d = do_q;
    if (wr_data) begin
      case (wr_idx_q)
        fdis_pkg::IDX_CFG_CTRL: cc_d = HWDATA_I[2:0];
        fdis_pkg::IDX_MODE: mode_d = HWDATA_I[1:0];
        fdis_pkg::IDX_DIG_OUT: do_d = HWDATA_I[4:0];
        default: cc_d = cc_q;
      endcase
    end
  end

  // config_control store
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cc_q <= fdis_pkg::CC_RESET;
    end else begin
      cc_q <= cc_d;
    end
  end

  // mode store
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mode_q <= fdis_pkg::MODE_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  // digital output image store
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      do_q <= fdis_pkg::DO_RESET;
    end else begin
      do_q <= do_d;
    end
  end

  // ----------------------------------------------------------------
  // settings steering the data path
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      PRECOMP_EN_O <= 1'b1;
      RATE_SEL_O <= fdis_pkg::CC_RESET[1:0];
      DMA_ALLOW_O <= 1'b0;
    end else begin
      PRECOMP_EN_O <= !cc_d[fdis_pkg::CC_PRECOMP_OFF];
      RATE_SEL_O <= cc_d[1:0];
      DMA_ALLOW_O <= do_d[fdis_pkg::DO_DMA_ALLOW];
    end
  end

  // ----------------------------------------------------------------
  // disk input word, one layout per mode
  // ----------------------------------------------------------------
  fdis_pkg::fdis_mode_t mode_sel;  // decoded layout
  logic [7:0] di_val;              // disk input value
  logic [7:0] di_en;               // bits actually driven
  logic dense_n;                   // dense_media_n
  logic [1:0] rate_now;            // rate at read time

  // unknown codes fall back to the basic layout
  always_comb begin
    case (mode_d)
      fdis_pkg::MODE_CODE_SECOND: mode_sel = fdis_pkg::FDIS_SECOND;
      fdis_pkg::MODE_CODE_THIRD: mode_sel = fdis_pkg::FDIS_THIRD;
      default: mode_sel = fdis_pkg::FDIS_BASIC;
    endcase
  end

  assign rate_now = cc_d[1:0];
  // low only for the two dense rates
  assign dense_n = !((rate_now == fdis_pkg::RATE_500K) ||
                     (rate_now == fdis_pkg::RATE_1M));

  // layout mux, sampled from the live state of this cycle
  always_comb begin
    di_val = 8'h00;
    di_en = 8'hFF;
    case (mode_sel)
      fdis_pkg::FDIS_SECOND: begin
        di_val = fdis_pkg::DI_SECOND_ONES;
        di_val[fdis_pkg::DI_CHANGE] = !chg_n_s;
        di_val[2:1] = rate_now;
        di_val[fdis_pkg::DI_DENSE] = dense_n;
      end
      fdis_pkg::FDIS_THIRD: begin
        di_val[fdis_pkg::DI_CHANGE] = chg_n_s;
        di_val[6:4] = 3'h0;
        di_val[fdis_pkg::DI_DMA] = do_d[fdis_pkg::DO_DMA_ALLOW];
        di_val[fdis_pkg::DI_PRECOMP] = cc_d[fdis_pkg::CC_PRECOMP_OFF];
        di_val[1:0] = rate_now;
      end
      default: begin
        // the low bits belong to another controller on a shared bus
        di_val[fdis_pkg::DI_CHANGE] = !chg_n_s;
        di_en = 8'h80;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // third result byte
  // ----------------------------------------------------------------
  logic [7:0] res3;  // result_status_three

  always_comb begin
    res3 = 8'h00;
    res3[fdis_pkg::R3_FAULT] = fault_s;
    res3[fdis_pkg::R3_WPROT] = wprot_s;
    res3[fdis_pkg::R3_READY] = ready_s;
    res3[fdis_pkg::R3_TRACK0] = track0_s;
    res3[fdis_pkg::R3_TWO_SIDED] = two_sided_s;
    res3[fdis_pkg::R3_HEAD] = do_d[fdis_pkg::DO_HEAD];
    res3[fdis_pkg::R3_UNIT_HI] = do_d[fdis_pkg::DO_UNIT_HI];
    res3[fdis_pkg::R3_UNIT_LO] = do_d[fdis_pkg::DO_UNIT_LO];
  end

  // ----------------------------------------------------------------
  // read data, registered at the address phase edge
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;  // selected register value
  logic [7:0] rd_en;    // drive enables of selection

  always_comb begin
    rd_byte = 8'h00;
    rd_en = 8'hFF;
    if (addr_ok) begin
      case (idx)
        fdis_pkg::IDX_DISK_INPUT: begin
          rd_byte = di_val & di_en;
          rd_en = di_en;
        end
        fdis_pkg::IDX_CFG_CTRL: rd_byte = {5'h00, cc_d};
        fdis_pkg::IDX_MODE: rd_byte = {6'h00, mode_d};
        fdis_pkg::IDX_DIG_OUT: rd_byte = {3'h0, do_d};
        fdis_pkg::IDX_RESULT3: rd_byte = res3;
        default: rd_byte = 8'h00;  // unmapped reads zero
      endcase
    end
  end

  // bits 31..8 always read zero
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      HRDATA_O <= 32'h00000000;
      DI_DRIVE_O <= 8'h00;
    end else if (ahb_rd) begin
      HRDATA_O <= {24'h000000, rd_byte};
      DI_DRIVE_O <= rd_en;
    end
  end

  // no wait states and no errors in this slave
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic rd_di;  // read of the disk input word taken
  assign rd_di = ahb_rd && addr_ok && (idx == fdis_pkg::IDX_DISK_INPUT);

  property p_di_ro;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (wr_pend_q && wr_idx_q == fdis_pkg::IDX_DISK_INPUT)
      |=> (cc_q == $past(cc_q)) && (do_q == $past(do_q))
          && (mode_q == $past(mode_q));
  endproperty
  a_di_ro: assert property (p_di_ro) else $error("disk input write changed state");

  property p_basic;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (rd_di && mode_sel == fdis_pkg::FDIS_BASIC)
      |=> (HRDATA_O[7] == !$past(chg_n_s)) && (DI_DRIVE_O == 8'h80)
          && (HRDATA_O[6:0] == 7'h00);
  endproperty
  a_basic: assert property (p_basic) else $error("basic layout wrong");

  property p_second;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (rd_di && mode_sel == fdis_pkg::FDIS_SECOND)
      |=> (HRDATA_O[7:3] == {!$past(chg_n_s), 4'hF})
          && (HRDATA_O[2:1] == $past(rate_now)) && (DI_DRIVE_O == 8'hFF);
  endproperty
  a_second: assert property (p_second) else $error("second layout wrong");

  property p_dense;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (rd_di && mode_sel == fdis_pkg::FDIS_SECOND && rate_now == fdis_pkg::RATE_1M)
      |=> (HRDATA_O[0] == 1'b0);
  endproperty
  a_dense: assert property (p_dense) else $error("density bit wrong");

  property p_third;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (rd_di && mode_sel == fdis_pkg::FDIS_THIRD)
      |=> (HRDATA_O[7:4] == {$past(chg_n_s), 3'h0})
          && (HRDATA_O[3] == $past(do_d[3])) && (HRDATA_O[2:0] == $past(cc_d));
  endproperty
  a_third: assert property (p_third) else $error("third layout wrong");

  property p_res3;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (ahb_rd && addr_ok && idx == fdis_pkg::IDX_RESULT3)
      |=> (HRDATA_O[7:3] == $past({fault_s, wprot_s, ready_s, track0_s, two_sided_s}));
  endproperty
  a_res3: assert property (p_res3) else $error("result byte layout wrong");

  property p_precomp;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (wr_pend_q && wr_idx_q == fdis_pkg::IDX_CFG_CTRL && HWDATA_I[2])
      |=> !PRECOMP_EN_O ##1 (!PRECOMP_EN_O || $past(cc_d[2]) == 1'b0);
  endproperty
  a_precomp: assert property (p_precomp) else $error("precomp not disabled");

  property p_mode_live;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (wr_pend_q && wr_idx_q == fdis_pkg::IDX_MODE
       && HWDATA_I[1:0] == fdis_pkg::MODE_CODE_THIRD && rd_di)
      |=> (DI_DRIVE_O == 8'hFF) && (HRDATA_O[6:4] == 3'h0);
  endproperty
  a_mode_live: assert property (p_mode_live) else $error("mode not used at read");

endmodule : fdis_top
